// [rtl/supply_watchdog_supervisor.sv]
// How it works
// - Resets held while low, then timeout
// - Active-high reset always inverts active-low
// - Backup operation always keeps resets asserted
// - Static strobe past timeout faults and resets
// - Any strobe edge or pulse restarts timer
// - Floating strobe level disables the watchdog
// - Watchdog off, fault high when disabled
// - Timeout: reset period, fault low until edge
// - Watchdog restarts after each watchdog reset
// - Select and input high: long periods
// - Input low: short period, long first
// - External clock: count 1024/4096/2048 edges
// - Chip-select passes normally, blocked in reset
// - Grace ends on input high or 15us
// - Power-up keeps chip-select path closed
// - Disabled path drives chip-select output high
// - Supply-low flag follows comparator directly
// - Early warning touches nothing else
// - Early warning low when input below
`timescale 1ns/1ps
`include "supervisor_cfg.svh"

module supply_watchdog_supervisor #(
  parameter int RESET_CYCLES    = int'(`SWS_RESET_CYCLES),
  parameter int WD_LONG_CYCLES  = int'(`SWS_WD_LONG_CYCLES),
  parameter int WD_SHORT_CYCLES = int'(`SWS_WD_SHORT_CYCLES)
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_supply_low,
  input  wire logic       i_backup_active,
  input  wire logic [1:0] i_watchdog_strobe_in,
  input  wire logic       i_timebase_select,
  input  wire logic       i_timebase_input,
  input  wire logic       i_ce_in_n,
  input  wire logic       i_early_warning_below,
  output logic            o_reset_n,
  output logic            o_reset_out,
  output logic            o_reset_oe,
  output logic            o_watchdog_fault_out_n,
  output logic            o_ce_out_n,
  output logic            o_ce_pullup_on,
  output logic            o_supply_low_n,
  output logic            o_early_warning_out,
  output logic            o_backup_active_out
);

  localparam logic [`SWS_GRACE_W-1:0] GRACE_CYCLES =
    `SWS_GRACE_W'(`SWS_CE_GRACE_CYCLES);

  supervisor_pkg::state_t        state_q;
  supervisor_pkg::state_t        state_d;
  supervisor_pkg::strobe_level_t level_q;
  supervisor_pkg::strobe_level_t level_d;
  supervisor_pkg::strobe_level_t level_now;

  logic                    tb_q;
  logic                    tb_rise;
  logic                    ext_mode;
  logic                    supply_bad;
  logic                    strobe_edge;
  logic                    strobe_float;
  logic                    wd_en;
  logic                    wd_timeout;
  logic                    first_q;
  logic                    first_d;
  logic                    fault_n_q;
  logic                    fault_n_d;
  logic                    ce_en_q;
  logic                    ce_en_d;
  logic [`SWS_GRACE_W-1:0] grace_q;
  logic [`SWS_GRACE_W-1:0] grace_d;
  logic                    reset_n_q;
  logic                    reset_od_oe_q;
  logic                    ce_out_n_q;
  logic                    ce_pullup_q;
  logic                    supply_low_n_q;
  logic                    early_q;
  logic                    backup_q;
  logic                    reset_n_d;
  logic                    reset_od_oe_d;
  logic                    ce_out_n_d;
  logic                    ce_pullup_d;
  logic                    supply_low_n_d;
  logic                    early_d;
  logic                    backup_d;
  logic                    tb_d;

  timer_if rst_tmr ();
  timer_if wd_tmr ();

  function automatic logic [`SWS_TMR_W-1:0] to_limit(input int cycles);
    to_limit = `SWS_TMR_W'(cycles);
  endfunction : to_limit

  // Unused strobe code reads as floating, so a bad level disables the
  // watchdog instead of faking activity
  function automatic supervisor_pkg::strobe_level_t decode_level(input logic [1:0] code);
    unique case (code)
      supervisor_pkg::LVL_LOW:  decode_level = supervisor_pkg::LVL_LOW;
      supervisor_pkg::LVL_HIGH: decode_level = supervisor_pkg::LVL_HIGH;
      default:                  decode_level = supervisor_pkg::LVL_FLOAT;
    endcase
  endfunction : decode_level

  function automatic logic is_run(input supervisor_pkg::state_t st);
    is_run = (st == supervisor_pkg::ST_RUN);
  endfunction : is_run

  // External mode advances the timers on timebase rising edges only
  function automatic logic tick(input logic ext, input logic rise);
    tick = ext ? rise : 1'b1;
  endfunction : tick

  // Inputs are already digital and synchronous to the block clock
  assign level_now    = decode_level(i_watchdog_strobe_in);
  assign supply_bad   = i_supply_low | i_backup_active;
  assign strobe_float = (level_now == supervisor_pkg::LVL_FLOAT);
  // Any change of level counts; a single-cycle pulse gives two changes
  assign strobe_edge  = (level_now != level_q);
  assign ext_mode     = ~i_timebase_select;
  assign tb_rise      = i_timebase_input & ~tb_q;
  assign wd_en        = is_run(state_q) && !supply_bad && !strobe_float;
  // Expiry wins over a same-cycle strobe edge
  assign wd_timeout   = wd_en && wd_tmr.expired;

  // Reset timer runs only while a timed release is in progress
  assign rst_tmr.start = (state_q != supervisor_pkg::ST_RELEASE)
                         && (state_q != supervisor_pkg::ST_WD_HOLD);
  assign rst_tmr.run   = ~rst_tmr.start;
  assign rst_tmr.step  = tick(ext_mode, tb_rise);
  assign rst_tmr.limit = ext_mode ? `SWS_EXT_RESET : to_limit(RESET_CYCLES);

  // Held cleared while disabled so re-enabling starts a fresh period
  assign wd_tmr.start = ~wd_en | strobe_edge;
  assign wd_tmr.run   = wd_en;
  assign wd_tmr.step  = tick(ext_mode, tb_rise);

  always_comb begin
    if (ext_mode) begin
      wd_tmr.limit = first_q ? `SWS_EXT_WD_FIRST : `SWS_EXT_WD_NORMAL;
    end else if (first_q || i_timebase_input) begin
      wd_tmr.limit = to_limit(WD_LONG_CYCLES);
    end else begin
      wd_tmr.limit = to_limit(WD_SHORT_CYCLES);
    end
  end

  period_timer u_rst_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .tmr       (rst_tmr)
  );

  period_timer u_wd_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .tmr       (wd_tmr)
  );

  // Reset sequencing
  always_comb begin
    state_d = state_q;
    first_d = first_q;
    if (supply_bad) begin
      state_d = supervisor_pkg::ST_SUPPLY_LOW;
    end else begin
      unique case (state_q)
        supervisor_pkg::ST_SUPPLY_LOW: begin
          state_d = supervisor_pkg::ST_RELEASE;
        end
        supervisor_pkg::ST_RELEASE: begin
          if (rst_tmr.expired) begin
            state_d = supervisor_pkg::ST_RUN;
            first_d = 1'b1;
          end
        end
        supervisor_pkg::ST_RUN: begin
          if (wd_timeout) begin
            state_d = supervisor_pkg::ST_WD_HOLD;
          end else if (strobe_edge) begin
            first_d = 1'b0;
          end
        end
        supervisor_pkg::ST_WD_HOLD: begin
          if (rst_tmr.expired) begin
            state_d = supervisor_pkg::ST_RUN;
            first_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= supervisor_pkg::ST_SUPPLY_LOW;
      first_q <= 1'b1;
    end else begin
      state_q <= state_d;
      first_q <= first_d;
    end
  end

  // Edge history; reset to the idle pin levels so no false edge follows
  always_comb begin
    level_d = level_now;
    tb_d    = i_timebase_input;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      level_q <= supervisor_pkg::LVL_FLOAT;
      tb_q    <= 1'b1;
    end else begin
      level_q <= level_d;
      tb_q    <= tb_d;
    end
  end

  // Watchdog fault; timeout wins over a same-cycle edge
  always_comb begin
    fault_n_d = fault_n_q;
    if (wd_timeout) begin
      fault_n_d = 1'b0;
    end else if (supply_bad || strobe_float) begin
      fault_n_d = 1'b1;
    end else if (strobe_edge) begin
      fault_n_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fault_n_q <= 1'b1;
    end else begin
      fault_n_q <= fault_n_d;
    end
  end

  // Chip-select gating
  always_comb begin
    ce_en_d = ce_en_q;
    grace_d = grace_q;
    if (is_run(state_d)) begin
      ce_en_d = 1'b1;
      grace_d = '0;
    end else if (ce_en_q) begin
      // Grace only exists when reset falls on an open path
      grace_d = grace_q + `SWS_GRACE_W'(1);
      if (i_ce_in_n || (grace_d >= GRACE_CYCLES)) begin
        ce_en_d = 1'b0;
      end
    end else begin
      ce_en_d = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ce_en_q <= 1'b0;
      grace_q <= '0;
    end else begin
      ce_en_q <= ce_en_d;
      grace_q <= grace_d;
    end
  end

  // Output stage; costs one cycle of latency on every path
  always_comb begin
    reset_n_d      = is_run(state_d);
    reset_od_oe_d  = is_run(state_d);
    ce_out_n_d     = ce_en_d ? i_ce_in_n : 1'b1;
    ce_pullup_d    = ~ce_en_d;
    supply_low_n_d = ~i_supply_low;
    early_d        = ~i_early_warning_below;
    backup_d       = i_backup_active;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      reset_n_q      <= 1'b0;
      reset_od_oe_q  <= 1'b0;
      ce_out_n_q     <= 1'b1;
      ce_pullup_q    <= 1'b1;
      supply_low_n_q <= 1'b0;
      early_q        <= 1'b0;
      backup_q       <= 1'b0;
    end else begin
      reset_n_q      <= reset_n_d;
      reset_od_oe_q  <= reset_od_oe_d;
      ce_out_n_q     <= ce_out_n_d;
      ce_pullup_q    <= ce_pullup_d;
      supply_low_n_q <= supply_low_n_d;
      early_q        <= early_d;
      backup_q       <= backup_d;
    end
  end

  assign o_reset_n              = reset_n_q;
  assign o_reset_out            = 1'b0;
  assign o_reset_oe             = reset_od_oe_q;
  assign o_watchdog_fault_out_n = fault_n_q;
  assign o_ce_out_n             = ce_out_n_q;
  assign o_ce_pullup_on         = ce_pullup_q;
  assign o_supply_low_n         = supply_low_n_q;
  assign o_early_warning_out    = early_q;
  assign o_backup_active_out    = backup_q;

endmodule : supply_watchdog_supervisor

// [rtl/supervisor_cfg.svh]
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

`define SWS_CLK_HZ          64'd10000000
`define SWS_TMR_W           24
`define SWS_RESET_MS        64'd200
`define SWS_WD_LONG_MS      64'd1600
`define SWS_WD_SHORT_MS     64'd100
`define SWS_CE_GRACE_US     64'd15
`define SWS_RESET_CYCLES    ((`SWS_RESET_MS * `SWS_CLK_HZ) / 64'd1000)
`define SWS_WD_LONG_CYCLES  ((`SWS_WD_LONG_MS * `SWS_CLK_HZ) / 64'd1000)
`define SWS_WD_SHORT_CYCLES ((`SWS_WD_SHORT_MS * `SWS_CLK_HZ) / 64'd1000)
`define SWS_CE_GRACE_CYCLES ((`SWS_CE_GRACE_US * `SWS_CLK_HZ) / 64'd1000000)
`define SWS_EXT_WD_NORMAL   24'h000400
`define SWS_EXT_WD_FIRST    24'h001000
`define SWS_EXT_RESET       24'h000800
`define SWS_GRACE_W         8

`endif

// [rtl/supervisor_pkg.sv]
package supervisor_pkg;

  typedef enum logic [1:0] {
    ST_SUPPLY_LOW = 2'b00,
    ST_RELEASE    = 2'b01,
    ST_RUN        = 2'b10,
    ST_WD_HOLD    = 2'b11
  } state_t;

  typedef enum logic [1:0] {
    LVL_LOW   = 2'b00,
    LVL_HIGH  = 2'b01,
    LVL_FLOAT = 2'b10
  } strobe_level_t;

endpackage : supervisor_pkg

// [rtl/timer_if.sv]
`timescale 1ns/1ps
`include "supervisor_cfg.svh"

interface timer_if;
  logic                   start;
  logic                   run;
  logic                   step;
  logic [`SWS_TMR_W-1:0]  limit;
  logic                   expired;

  modport ctrl  (output start, output run, output step, output limit, input expired);
  modport timer (input start, input run, input step, input limit, output expired);
endinterface : timer_if

// [rtl/period_timer.sv]
`timescale 1ns/1ps
`include "supervisor_cfg.svh"

module period_timer (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_b,
  timer_if.timer    tmr
);

  logic [`SWS_TMR_W-1:0] cnt_q;
  logic [`SWS_TMR_W-1:0] cnt_d;
  logic                  done_q;
  logic                  done_d;

  // Done is sticky until the next start, so a late reader never misses it
  always_comb begin
    cnt_d  = cnt_q;
    done_d = done_q;
    if (tmr.start) begin
      cnt_d  = '0;
      done_d = 1'b0;
    end else if (tmr.run && tmr.step && !done_q) begin
      cnt_d = cnt_q + `SWS_TMR_W'(1);
      if (cnt_d >= tmr.limit) begin
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign tmr.expired = done_q;

endmodule : period_timer

// [dv/host_model.sv]
`timescale 1ns/1ps
module host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [1:0] i_mode,
  output logic      [1:0] o_strobe
);
  int cnt = 0;
  initial o_strobe = 2'h0;
  // Mode 0 holds the strobe, 1 kicks every 20 cycles, 2 floats it
  always @(negedge i_ref_clk) begin
    cnt <= (cnt == 19) ? 0 : cnt + 1;
    if (i_mode == 2'h2) begin
      o_strobe <= 2'h2;
    end else if (o_strobe == 2'h2) begin
      o_strobe <= 2'h0;
    end else if (i_mode == 2'h1 && cnt == 19) begin
      o_strobe <= {1'b0, ~o_strobe[0]};
    end
  end
endmodule : host_model

// [dv/supply_watchdog_supervisor_chk.sv]
`timescale 1ns/1ps
module supply_watchdog_supervisor_chk (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_b,
  input wire logic       i_supply_low,
  input wire logic       i_backup_active,
  input wire logic [1:0] i_watchdog_strobe_in,
  input wire logic       i_ce_in_n,
  input wire logic       i_early_warning_below,
  input wire logic       o_reset_n,
  input wire logic       o_reset_out,
  input wire logic       o_reset_oe,
  input wire logic       o_watchdog_fault_out_n,
  input wire logic       o_ce_out_n,
  input wire logic       o_ce_pullup_on,
  input wire logic       o_supply_low_n,
  input wire logic       o_early_warning_out
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  property p_inv;
    o_reset_out == 1'b0 && o_reset_oe == o_reset_n;
  endproperty
  a_inv: assert property (p_inv) else $error("reset pair differs");
  property p_low;
    i_supply_low |=> !o_reset_n;
  endproperty
  a_low: assert property (p_low) else $error("reset not set on low supply");
  property p_bak;
    i_backup_active |=> !o_reset_n;
  endproperty
  a_bak: assert property (p_bak) else $error("reset not set in backup");
  property p_flag;
    1'b1 |=> o_supply_low_n == !$past(i_supply_low);
  endproperty
  a_flag: assert property (p_flag) else $error("supply flag wrong");
  property p_ew;
    1'b1 |=> o_early_warning_out == !$past(i_early_warning_below);
  endproperty
  a_ew: assert property (p_ew) else $error("early warning wrong");
  property p_float;
    i_watchdog_strobe_in == 2'h2 |-> ##[1:2] o_watchdog_fault_out_n;
  endproperty
  a_float: assert property (p_float) else $error("fault while floating");
  // Grace bound is 150 cycles plus register slack
  property p_grace;
    $fell(o_reset_n) |-> ##[0:153] o_ce_pullup_on;
  endproperty
  a_grace: assert property (p_grace) else $error("grace window too long");
  property p_drive;
    o_ce_pullup_on |-> o_ce_out_n;
  endproperty
  a_drive: assert property (p_drive) else $error("closed path not high");
  property p_pass;
    !o_ce_pullup_on |-> o_ce_out_n == $past(i_ce_in_n);
  endproperty
  a_pass: assert property (p_pass) else $error("open path not passing");
  property p_wdrst;
    $fell(o_watchdog_fault_out_n) |-> ##[0:2] !o_reset_n;
  endproperty
  a_wdrst: assert property (p_wdrst) else $error("fault without reset");
endmodule : supply_watchdog_supervisor_chk

bind supply_watchdog_supervisor supply_watchdog_supervisor_chk chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_supply_low(i_supply_low),
  .i_backup_active(i_backup_active), .i_watchdog_strobe_in(i_watchdog_strobe_in),
  .i_ce_in_n(i_ce_in_n), .i_early_warning_below(i_early_warning_below),
  .o_reset_n(o_reset_n), .o_reset_out(o_reset_out), .o_reset_oe(o_reset_oe),
  .o_watchdog_fault_out_n(o_watchdog_fault_out_n), .o_ce_out_n(o_ce_out_n),
  .o_ce_pullup_on(o_ce_pullup_on), .o_supply_low_n(o_supply_low_n),
  .o_early_warning_out(o_early_warning_out));

// [dv/supply_watchdog_supervisor_test.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) err(a, b); end
module supply_watchdog_supervisor_test;
  localparam int RC = 200;
  localparam int LC = 400;
  localparam int SC = 40;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       low = 1'b1;
  logic       bak = 1'b0;
  logic       sel = 1'b1;
  logic       tbi = 1'b1;
  logic       ext = 1'b0;
  logic       ce_n = 1'b0;
  logic       ew = 1'b1;
  logic [1:0] mode = 2'h1;
  logic [1:0] watchdog_strobe_in;
  logic       reset_n, ro, roe, fault_n, ceo_n, cpu, sln, ewo, bo;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         n;
  int         bad;
  time        t0;
  always #50 clk = ~clk;
  always @(negedge clk) if (ext) tbi <= ~tbi;
  host_model host (.i_ref_clk(clk), .i_mode(mode), .o_strobe(watchdog_strobe_in));
  supply_watchdog_supervisor #(.RESET_CYCLES(RC), .WD_LONG_CYCLES(LC), .WD_SHORT_CYCLES(SC)) uut (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_supply_low(low), .i_backup_active(bak),
    .i_watchdog_strobe_in(watchdog_strobe_in), .i_timebase_select(sel), .i_timebase_input(tbi),
    .i_ce_in_n(ce_n), .i_early_warning_below(ew), .o_reset_n(reset_n), .o_reset_out(ro),
    .o_reset_oe(roe), .o_watchdog_fault_out_n(fault_n), .o_ce_out_n(ceo_n),
    .o_ce_pullup_on(cpu), .o_supply_low_n(sln), .o_early_warning_out(ewo),
    .o_backup_active_out(bo));
  task err(input logic [31:0] a, input logic [31:0] b);
    fail_count++;
    $display("wrong value at %0t: %h %h", $time, a, b);
  endtask : err
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  // Bounded wait on reset (w=0) or fault (w=1), n counts cycles
  task wait_sig(input int w, input logic v);
    n = 0;
    while ((w ? fault_n : reset_n) !== v && n < 30000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_sig
  task quiet(input int k);
    bad = 0;
    repeat (k) begin
      @(negedge clk);
      if (reset_n !== 1'b1 || fault_n !== 1'b1) bad++;
    end
  endtask : quiet
  task t_power;
    cyc(10);
    `CHK(reset_n, 1'b0)
    `CHK(sln, 1'b0)
    `CHK(cpu, 1'b1)
    `CHK(ceo_n, 1'b1)
    `CHK(ewo, 1'b0)
    low = 1'b0;
    wait_sig(0, 1'b1);
    `CHK(n >= RC - 2 && n <= RC + 4, 1'b1)
    `CHK(roe, 1'b1)
    $display("test power done");
  endtask : t_power
  task t_kick;
    quiet(1000);
    `CHK(bad, 0)
    cyc(2);
    `CHK(ceo_n, 1'b0)
    ce_n = 1'b1;
    ew = 1'b0;
    cyc(2);
    `CHK(ceo_n, 1'b1)
    `CHK(ewo, 1'b1)
    `CHK(reset_n, 1'b1)
    $display("test kick done");
  endtask : t_kick
  task t_static;
    mode = 2'h0;
    ce_n = 1'b0;
    wait_sig(1, 1'b0);
    t0 = $time;
    `CHK(n >= LC - 22 && n <= LC + 4, 1'b1)
    cyc(3);
    `CHK(reset_n, 1'b0)
    `CHK(ceo_n, 1'b0)
    ce_n = 1'b1;
    cyc(2);
    `CHK(cpu, 1'b1)
    ce_n = 1'b0;
    cyc(2);
    `CHK(ceo_n, 1'b1)
    wait_sig(0, 1'b1);
    n = ($time - t0) / 100;
    `CHK(n >= RC - 2 && n <= RC + 5, 1'b1)
    `CHK(fault_n, 1'b0)
    wait_sig(0, 1'b0);
    `CHK(n >= LC - 2 && n <= LC + 5, 1'b1)
    wait_sig(0, 1'b1);
    mode = 2'h1;
    wait_sig(1, 1'b1);
    `CHK(n <= 25, 1'b1)
    $display("test static done");
  endtask : t_static
  task t_short;
    tbi = 1'b0;
    cyc(100);
    mode = 2'h0;
    wait_sig(1, 1'b0);
    `CHK(n >= SC - 22 && n <= SC + 4, 1'b1)
    wait_sig(0, 1'b1);
    `CHK(n >= RC - 4 && n <= RC + 5, 1'b1)
    wait_sig(0, 1'b0);
    `CHK(n >= LC - 2 && n <= LC + 5, 1'b1)
    wait_sig(0, 1'b1);
    mode = 2'h1;
    tbi = 1'b1;
    cyc(30);
    $display("test short done");
  endtask : t_short
  task t_float;
    mode = 2'h2;
    quiet(600);
    `CHK(bad, 0)
    mode = 2'h1;
    cyc(40);
    $display("test float done");
  endtask : t_float
  task t_backup;
    bak = 1'b1;
    cyc(3);
    `CHK(reset_n, 1'b0)
    `CHK(fault_n, 1'b1)
    `CHK(bo, 1'b1)
    bak = 1'b0;
    wait_sig(0, 1'b1);
    `CHK(n >= RC - 2 && n <= RC + 4, 1'b1)
    cyc(20);
    $display("test backup done");
  endtask : t_backup
  // One timebase rising edge every two cycles
  task t_ext;
    sel = 1'b0;
    ext = 1'b1;
    mode = 2'h0;
    wait_sig(1, 1'b0);
    t0 = $time;
    wait_sig(0, 1'b1);
    n = ($time - t0) / 100;
    `CHK(n >= 4088 && n <= 4106, 1'b1)
    wait_sig(0, 1'b0);
    `CHK(n >= 8184 && n <= 8206, 1'b1)
    mode = 2'h1;
    sel = 1'b1;
    ext = 1'b0;
    cyc(10);
    $display("test ext done");
  endtask : t_ext
  task results;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    #5000000;
    fail_count++;
    results;
  end
  initial begin
    cyc(8);
    rst_b = 1'b1;
    t_power;
    t_kick;
    t_static;
    t_short;
    t_float;
    t_backup;
    t_ext;
    results;
  end
endmodule : supply_watchdog_supervisor_test
